// *** pkg/restart_pkg.sv ***
// Package: register map, field layouts, timing constants and carriers for the restart controller
package restart_pkg;
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned TICK_MS = 100;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned CALM_TIME_S = 30;
	localparam int unsigned CALM_TICKS = CALM_TIME_S * 1000 / TICK_MS;
	localparam logic [3:0] ADDR_RETRY_COUNT = 4'h0;
	localparam logic [3:0] ADDR_DELAY_TIME = 4'h1;
	localparam logic [3:0] ADDR_SEARCH_LIMIT = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
	localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h6;
	localparam logic [3:0] RETRY_MAX = 4'ha;
	localparam logic [3:0] RETRY_RESET = 4'h0;
	localparam logic [15:0] DELAY_MAX = 16'h0258;
	localparam logic [15:0] DELAY_RESET = 16'h000a;
	localparam logic [7:0] LIMIT_MIN = 8'h50;
	localparam logic [7:0] LIMIT_MAX = 8'hc8;
	localparam logic [7:0] LIMIT_RESET = 8'h64;
	localparam int unsigned EV_TRIP = 0;
	localparam int unsigned EV_RESTART = 1;
	localparam int unsigned EV_LOCKOUT = 2;
	localparam int unsigned EV_RELOAD = 3;
	localparam int unsigned EV_W = 4;
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic trip;
		logic low_voltage;
		logic emergency_stop_trip;
		logic fault_reset;
		logic stop_cmd;
	} trip_in_t;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SEARCH, ST_LOCKED} restart_state_t;
endpackage : restart_pkg

// *** hdl/tick_counter.sv ***
// Free-running divider making one pulse per tick interval
`timescale 1ns/1ps
`default_nettype none
module tick_counter import restart_pkg::*; #(
	parameter int unsigned CYCLES = TICK_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	output logic tick_o
);
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic tick_next;
	always_comb begin
		tick_next = (count_reg == 32'(CYCLES - 1));
		count_next = tick_next ? 32'h0 : count_reg + 32'h1;
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			count_reg <= 32'h0;
			tick_o <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_o <= tick_next;
		end
	end
endmodule : tick_counter
`default_nettype wire

// *** hdl/sticky_flags.sv ***
// Sticky event flags with enable mask, write-one clear and level interrupt
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
	parameter int unsigned W = 4
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [W-1:0] event_i,
	input wire logic [W-1:0] clear_i,
	input wire logic enable_wr_i,
	input wire logic [W-1:0] enable_data_i,
	output logic [W-1:0] status_o,
	output logic [W-1:0] enable_o,
	output logic irq_o
);
	logic [W-1:0] status_next;
	logic [W-1:0] enable_next;
	logic irq_next;
	always_comb begin
		// A new event wins over a clear in the same cycle
		status_next = (status_o & ~clear_i) | event_i;
		enable_next = enable_wr_i ? enable_data_i : enable_o;
		irq_next = |(status_next & enable_next);
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			status_o <= '0;
			enable_o <= '0;
			irq_o <= 1'b0;
		end else begin
			status_o <= status_next;
			enable_o <= enable_next;
			irq_o <= irq_next;
		end
	end
endmodule : sticky_flags
`default_nettype wire

// *** hdl/auto_restart_controller.sv ***
// Trip-recovery sequencer: delayed restart through speed search with a retry budget
// How it works
// - Programmable retry count 0 to 10, default 0, limits automatic restarts.
// - After a restartable trip, wait programmed delay 0-60 s, default 1.0 s.
// - Each automatic restart decrements the remaining retries by one.
// - With no retries left, a trip locks out restarting; drive stays stopped.
// - Fault reset from terminal or keypad reloads remaining retries from setting.
// - Thirty trip-free seconds after a completed speed search reload the remaining retries.
// - Low-voltage or emergency-stop trips in idle or lockout never restart, whatever retries remain; one during the delay wait is ignored.
// - When delay expires, restart by requesting speed search, not zero-frequency start.
// - Speed search current limit 80 to 200 percent of rated, default 100.
`timescale 1ns/1ps
`default_nettype none
module auto_restart_controller import restart_pkg::*; #(
	parameter int unsigned TICK_LEN = TICK_CYCLES,
	parameter int unsigned CALM_LEN = CALM_TICKS
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic trip_i,
	input wire logic low_voltage_trip_i,
	input wire logic emergency_stop_trip_i,
	input wire logic terminal_reset_i,
	input wire logic keypad_reset_i,
	input wire logic stop_cmd_i,
	input wire logic search_done_i,
	output logic [15:0] reg_rdata_o,
	output logic speed_search_start_o,
	output logic [7:0] speed_search_current_limit_o,
	output logic restart_pending_o,
	output logic irq_o
);
	reg_req_t req;
	trip_in_t trip_in;
	restart_state_t state_reg, state_next;
	logic [3:0] restart_retry_count_reg, restart_retry_count_next;
	logic [15:0] restart_delay_time_reg, restart_delay_time_next;
	logic [7:0] limit_reg, limit_next;
	logic [3:0] remaining_reg, remaining_next;
	logic [15:0] delay_cnt_reg, delay_cnt_next;
	logic [15:0] calm_cnt_reg, calm_cnt_next;
	logic calm_run_reg, calm_run_next;
	logic start_next;
	logic [15:0] rdata_next;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_enable;
	logic tick;
	logic fault_reset;

	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
	assign trip_in = '{trip: trip_i, low_voltage: low_voltage_trip_i,
		emergency_stop_trip: emergency_stop_trip_i, fault_reset: terminal_reset_i | keypad_reset_i,
		stop_cmd: stop_cmd_i};
	assign fault_reset = trip_in.fault_reset;

	tick_counter #(.CYCLES(TICK_LEN)) u_tick (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.tick_o(tick)
	);

	// Configuration registers; out-of-range writes are clamped
	always_comb begin
		restart_retry_count_next = restart_retry_count_reg;
		restart_delay_time_next = restart_delay_time_reg;
		limit_next = limit_reg;
		if (req.wr) begin
			unique case (req.addr)
				ADDR_RETRY_COUNT: restart_retry_count_next = (req.wdata[3:0] > RETRY_MAX || req.wdata[15:4] != 12'h0)
					? RETRY_MAX : req.wdata[3:0];
				ADDR_DELAY_TIME: restart_delay_time_next = (req.wdata > DELAY_MAX) ? DELAY_MAX : req.wdata;
				ADDR_SEARCH_LIMIT: begin
					if (req.wdata[15:8] != 8'h0 || req.wdata[7:0] > LIMIT_MAX)
						limit_next = LIMIT_MAX;
					else if (req.wdata[7:0] < LIMIT_MIN)
						limit_next = LIMIT_MIN;
					else
						limit_next = req.wdata[7:0];
				end
				default: ;
			endcase
		end
	end

	// Sequencer
	always_comb begin
		state_next = state_reg;
		remaining_next = remaining_reg;
		delay_cnt_next = delay_cnt_reg;
		calm_cnt_next = calm_cnt_reg;
		calm_run_next = calm_run_reg;
		start_next = 1'b0;
		events = '0;
		if (calm_run_reg && tick) begin
			if (calm_cnt_reg == 16'(CALM_LEN - 1)) begin
				calm_run_next = 1'b0;
				remaining_next = restart_retry_count_reg;
				events[EV_RELOAD] = 1'b1;
			end else begin
				calm_cnt_next = calm_cnt_reg + 16'h1;
			end
		end
		unique case (state_reg)
			ST_IDLE, ST_LOCKED: begin
				if (trip_in.trip) begin
					events[EV_TRIP] = 1'b1;
					calm_run_next = 1'b0;
					if (trip_in.low_voltage || trip_in.emergency_stop_trip || remaining_reg == 4'h0) begin
						state_next = ST_LOCKED;
						events[EV_LOCKOUT] = 1'b1;
					end else begin
						state_next = ST_WAIT;
						delay_cnt_next = 16'h0;
					end
				end
			end
			ST_WAIT: begin
				// Delay of zero ticks still waits for the next tick edge
				if (fault_reset || trip_in.stop_cmd) begin
					state_next = ST_IDLE;
				end else if (tick) begin
					if (delay_cnt_reg >= restart_delay_time_reg) begin
						state_next = ST_SEARCH;
						start_next = 1'b1;
						remaining_next = remaining_reg - 4'h1;
						events[EV_RESTART] = 1'b1;
					end else begin
						delay_cnt_next = delay_cnt_reg + 16'h1;
					end
				end
			end
			ST_SEARCH: begin
				if (trip_in.trip) begin
					state_next = ST_IDLE;
				end else if (search_done_i) begin
					state_next = ST_IDLE;
					calm_run_next = 1'b1;
					calm_cnt_next = 16'h0;
				end
			end
		endcase
		// Fault reset reloads retries in every state and releases a lockout
		if (fault_reset) begin
			remaining_next = restart_retry_count_reg;
			calm_run_next = 1'b0;
			events[EV_RELOAD] = 1'b1;
			if (state_reg == ST_LOCKED)
				state_next = ST_IDLE;
		end
		if (req.wr && req.addr == ADDR_RETRY_COUNT && state_reg == ST_IDLE)
			remaining_next = restart_retry_count_next;
	end

	sticky_flags #(.W(EV_W)) u_flags (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.event_i(events),
		.clear_i((req.wr && req.addr == ADDR_IRQ_CLEAR) ? req.wdata[EV_W-1:0] : '0),
		.enable_wr_i(req.wr && req.addr == ADDR_IRQ_ENABLE),
		.enable_data_i(req.wdata[EV_W-1:0]),
		.status_o(irq_status),
		.enable_o(irq_enable),
		.irq_o(irq_o)
	);

	// Read mux; unmapped and write-only addresses read zero
	always_comb begin
		rdata_next = 16'h0;
		if (req.rd) begin
			unique case (req.addr)
				ADDR_RETRY_COUNT: rdata_next = {12'h0, restart_retry_count_reg};
				ADDR_DELAY_TIME: rdata_next = restart_delay_time_reg;
				ADDR_SEARCH_LIMIT: rdata_next = {8'h0, limit_reg};
				ADDR_STATUS: rdata_next = {10'h0, state_reg, remaining_reg};
				ADDR_IRQ_STATUS: rdata_next = {12'h0, irq_status};
				ADDR_IRQ_ENABLE: rdata_next = {12'h0, irq_enable};
				default: rdata_next = 16'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			state_reg <= ST_IDLE;
			restart_retry_count_reg <= RETRY_RESET;
			restart_delay_time_reg <= DELAY_RESET;
			limit_reg <= LIMIT_RESET;
			remaining_reg <= RETRY_RESET;
			delay_cnt_reg <= 16'h0;
			calm_cnt_reg <= 16'h0;
			calm_run_reg <= 1'b0;
			speed_search_start_o <= 1'b0;
			speed_search_current_limit_o <= LIMIT_RESET;
			restart_pending_o <= 1'b0;
			reg_rdata_o <= 16'h0;
		end else begin
			state_reg <= state_next;
			restart_retry_count_reg <= restart_retry_count_next;
			restart_delay_time_reg <= restart_delay_time_next;
			limit_reg <= limit_next;
			remaining_reg <= remaining_next;
			delay_cnt_reg <= delay_cnt_next;
			calm_cnt_reg <= calm_cnt_next;
			calm_run_reg <= calm_run_next;
			speed_search_start_o <= start_next;
			speed_search_current_limit_o <= limit_next;
			restart_pending_o <= (state_next == ST_WAIT);
			reg_rdata_o <= rdata_next;
		end
	end

	a_retry_in_range: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		restart_retry_count_reg <= RETRY_MAX && remaining_reg <= RETRY_MAX)
		else $error("retry count out of range");
	a_delay_bounded: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		state_reg == ST_WAIT && delay_cnt_reg < restart_delay_time_reg && !fault_reset && !stop_cmd_i
		|=> !speed_search_start_o)
		else $error("restart before delay expired");
	a_start_decrements: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		speed_search_start_o && !$past(fault_reset) |-> remaining_reg == $past(remaining_reg) - 4'h1)
		else $error("restart did not decrement retries");
	a_lockout_empty: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_reg == ST_IDLE && trip_i && remaining_reg == 4'h0) |=> state_reg == ST_LOCKED)
		else $error("trip with no retries did not lock out");
	a_reset_reloads: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fault_reset && !(reg_wr_i && reg_addr_i == ADDR_RETRY_COUNT) |=> remaining_reg == $past(restart_retry_count_reg))
		else $error("fault reset did not reload retries");
	a_blocked_trips: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_reg != ST_WAIT && state_reg != ST_SEARCH && trip_i && (low_voltage_trip_i || emergency_stop_trip_i))
		|=> state_reg == ST_LOCKED ##1 !speed_search_start_o)
		else $error("blocked trip began a restart");
	a_start_after_wait: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(speed_search_start_o) |-> $past(state_reg) == ST_WAIT && state_reg == ST_SEARCH)
		else $error("speed search start without wait");
	a_limit_range: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		speed_search_current_limit_o >= LIMIT_MIN && speed_search_current_limit_o <= LIMIT_MAX)
		else $error("search current limit out of range");
	a_cancel_wait: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		state_reg == ST_WAIT && (stop_cmd_i || fault_reset) |=> state_reg == ST_IDLE && !speed_search_start_o)
		else $error("pending restart not cancelled");
	a_calm_reload: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		calm_run_reg && tick && calm_cnt_reg == 16'(CALM_LEN - 1) |=> remaining_reg == $past(restart_retry_count_reg))
		else $error("trip-free interval did not reload retries");
	a_pending_on_trip: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(restart_pending_o) |-> $past(trip_i))
		else $error("restart pending without a trip");
	a_start_one_cycle: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		speed_search_start_o |=> !speed_search_start_o)
		else $error("speed search start longer than one cycle");
	a_locked_holds: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		state_reg == ST_LOCKED && !fault_reset && !trip_i |=> state_reg == ST_LOCKED)
		else $error("lockout left without fault reset");
	a_locked_no_start: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		state_reg == ST_LOCKED |=> !speed_search_start_o)
		else $error("restart issued while locked out");
	a_wait_on_trip: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_reg == ST_IDLE || state_reg == ST_LOCKED) && trip_i && !fault_reset && !low_voltage_trip_i
		&& !emergency_stop_trip_i && remaining_reg != 4'h0 |=> state_reg == ST_WAIT)
		else $error("restartable trip did not start the delay");
	a_remaining_steady: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$past(state_reg) == ST_WAIT && !speed_search_start_o && !$past(fault_reset)
		|-> remaining_reg == $past(remaining_reg))
		else $error("retries changed without a restart");
	a_search_exit: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		state_reg == ST_SEARCH && (trip_i || search_done_i) |=> state_reg == ST_IDLE)
		else $error("speed search did not end");
	a_calm_after_search: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		state_reg == ST_SEARCH && search_done_i && !trip_i && !fault_reset |=> calm_run_reg)
		else $error("trip-free timer not started after search");
	a_trip_stops_calm: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		trip_i && state_reg != ST_WAIT |=> !calm_run_reg)
		else $error("trip did not stop the trip-free timer");
	a_delay_reached: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(speed_search_start_o) |-> $past(delay_cnt_reg) >= $past(restart_delay_time_reg))
		else $error("restart before delay count reached");
	a_rdata_quiet: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!reg_rd_i |=> reg_rdata_o == 16'h0)
		else $error("read data not zero outside a read");
	a_retry_clamp: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		reg_wr_i && reg_addr_i == ADDR_RETRY_COUNT && reg_wdata_i > {12'h0, RETRY_MAX}
		|=> restart_retry_count_reg == RETRY_MAX)
		else $error("retry count write not clamped");
	a_delay_clamp: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		reg_wr_i && reg_addr_i == ADDR_DELAY_TIME && reg_wdata_i > DELAY_MAX |=> restart_delay_time_reg == DELAY_MAX)
		else $error("delay write not clamped");
	a_limit_clamp_low: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		reg_wr_i && reg_addr_i == ADDR_SEARCH_LIMIT && reg_wdata_i < {8'h0, LIMIT_MIN} |=> limit_reg == LIMIT_MIN)
		else $error("search limit not clamped up");
	a_limit_clamp_high: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		reg_wr_i && reg_addr_i == ADDR_SEARCH_LIMIT && reg_wdata_i > {8'h0, LIMIT_MAX} |=> limit_reg == LIMIT_MAX)
		else $error("search limit not clamped down");
	a_search_entry: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		state_reg == ST_SEARCH && $past(state_reg) != ST_SEARCH |-> speed_search_start_o)
		else $error("search entered without start request");
	a_reset_unlocks: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		state_reg == ST_LOCKED && fault_reset |=> state_reg == ST_IDLE)
		else $error("fault reset did not release lockout");
	a_cancel_keeps_count: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		state_reg == ST_WAIT && stop_cmd_i && !fault_reset |=> remaining_reg == $past(remaining_reg))
		else $error("cancelled restart changed retries");
	c_restart: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) speed_search_start_o);
	c_lockout: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) state_reg == ST_LOCKED);
	c_cancel: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) state_reg == ST_WAIT && stop_cmd_i);
	c_calm: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) events[EV_RELOAD] && calm_run_reg);
	c_search_trip: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) state_reg == ST_SEARCH && trip_i);
endmodule : auto_restart_controller
`default_nettype wire

// *** bench/drive_side_model.sv ***
// Model of the protection logic and run controller around the restart controller
`timescale 1ns/1ps
`default_nettype none
module drive_side_model (
	input wire logic core_clk_i,
	input wire logic speed_search_start_i,
	output logic trip_o,
	output logic low_voltage_trip_o,
	output logic emergency_stop_trip_o,
	output logic search_done_o
);
	int lat = 1;
	initial begin
		trip_o = 1'b0;
		low_voltage_trip_o = 1'b1;
		emergency_stop_trip_o = 1'b1;
		search_done_o = 1'b0;
	end
	// One-cycle trip; causes are only meaningful beside it, so they flip afterwards
	task automatic fire(input logic lv, input logic es);
		@(posedge core_clk_i);
		trip_o <= 1'b1;
		low_voltage_trip_o <= lv;
		emergency_stop_trip_o <= es;
		@(posedge core_clk_i);
		trip_o <= 1'b0;
		low_voltage_trip_o <= ~lv;
		emergency_stop_trip_o <= ~es;
	endtask : fire
	// Speed search finishes after lat cycles
	initial forever begin
		@(posedge core_clk_i);
		if (speed_search_start_i === 1'b1) begin
			repeat (lat) @(posedge core_clk_i);
			search_done_o <= 1'b1;
			@(posedge core_clk_i);
			search_done_o <= 1'b0;
		end
	end
endmodule : drive_side_model
`default_nettype wire

// *** bench/auto_restart_controller_bench.sv ***
// Self-checking bench for the restart controller
`timescale 1ns/1ps
`default_nettype none
module auto_restart_controller_bench;
	import restart_pkg::*;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic term = 1'b0;
	logic key = 1'b0;
	logic stop = 1'b0;
	logic trip, lv, es, done, start, pending, irq;
	logic [15:0] rdata;
	logic [7:0] limit;
	int err_count = 0;
	int cmp_count = 0;
	logic [15:0] rv [8] = '{{12'h0, RETRY_RESET}, DELAY_RESET, {8'h0, LIMIT_RESET}, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
	logic [35:0] cl [5] = '{{4'h0, 16'hffff, 16'h000a}, {4'h1, 16'hffff, 16'h0258}, {4'h2, 16'h0010, 16'h0050},
		{4'h2, 16'hffff, 16'h00c8}, {4'h7, 16'h1234, 16'h0000}};

	auto_restart_controller #(.TICK_LEN(10), .CALM_LEN(5)) dut (
		.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .trip_i(trip), .low_voltage_trip_i(lv), .emergency_stop_trip_i(es),
		.terminal_reset_i(term), .keypad_reset_i(key), .stop_cmd_i(stop), .search_done_i(done),
		.reg_rdata_o(rdata), .speed_search_start_o(start), .speed_search_current_limit_o(limit),
		.restart_pending_o(pending), .irq_o(irq));
	drive_side_model mdl (.core_clk_i(core_clk_i), .speed_search_start_i(start), .trip_o(trip),
		.low_voltage_trip_o(lv), .emergency_stop_trip_o(es), .search_done_o(done));

	initial forever #5 core_clk_i = ~core_clk_i;

	task automatic tally_and_finish;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
		@(posedge core_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk_i);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rdchk
	// 0 terminal reset, 1 keypad reset, 2 stop command
	task automatic pulse(input int w);
		@(posedge core_clk_i);
		term <= (w == 0);
		key <= (w == 1);
		stop <= (w == 2);
		@(posedge core_clk_i);
		{term, key, stop} <= 3'b000;
	endtask : pulse
	// Looks for a speed-search start, then for the end of the search
	task automatic restart(input logic exp);
		logic seen;
		logic fin;
		seen = 1'b0;
		fin = !exp;
		for (int i = 0; i < 60 && !seen; i++)
			@(posedge core_clk_i) #1 seen = (start === 1'b1);
		chk({15'h0, seen}, {15'h0, exp});
		for (int i = 0; i < 40 && seen && !fin; i++)
			@(posedge core_clk_i) #1 fin = (done === 1'b1);
		// A missing start or a search that never ends is a timeout
		if (!fin) begin
			err_count++;
			tally_and_finish();
		end
	endtask : restart

	initial begin
		#900000;
		err_count++;
		tally_and_finish();
	end

	initial begin
		repeat (20) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		@(posedge core_clk_i) #1 chk({6'h0, irq, pending, limit}, {8'h0, LIMIT_RESET});
		for (int i = 0; i < 8; i++)
			rdchk(4'(i), rv[i]);
		for (int i = 0; i < 5; i++) begin
			wr_reg(cl[i][35:32], cl[i][31:16]);
			rdchk(cl[i][35:32], cl[i][15:0]);
		end
		chk({8'h0, limit}, {8'h0, LIMIT_MAX});
		wr_reg(ADDR_SEARCH_LIMIT, 16'h0064);
		wr_reg(ADDR_RETRY_COUNT, 16'h0002);
		wr_reg(ADDR_DELAY_TIME, 16'h0002);
		wr_reg(ADDR_IRQ_ENABLE, 16'h000f);
		rdchk(ADDR_IRQ_ENABLE, 16'h000f);
		mdl.fire(1'b0, 1'b0);
		@(posedge core_clk_i) #1 chk({14'h0, irq, pending}, 16'h0003);
		restart(1'b1);
		rdchk(ADDR_STATUS, 16'h0001);
		mdl.fire(1'b0, 1'b0);
		restart(1'b1);
		rdchk(ADDR_STATUS, 16'h0000);
		mdl.fire(1'b0, 1'b0);
		restart(1'b0);
		rdchk(ADDR_STATUS, 16'h0030);
		pulse(0);
		rdchk(ADDR_STATUS, 16'h0002);
		rdchk(ADDR_IRQ_STATUS, 16'h000f);
		chk({15'h0, irq}, 16'h0001);
		wr_reg(ADDR_IRQ_CLEAR, 16'h000f);
		wr_reg(ADDR_IRQ_ENABLE, 16'h0000);
		rdchk(ADDR_IRQ_STATUS, 16'h0000);
		mdl.lat = 20;
		mdl.fire(1'b0, 1'b0);
		restart(1'b1);
		rdchk(ADDR_STATUS, 16'h0001);
		repeat (80) @(posedge core_clk_i);
		rdchk(ADDR_STATUS, 16'h0002);
		rdchk(ADDR_IRQ_STATUS, 16'h000b);
		chk({15'h0, irq}, 16'h0000);
		mdl.fire(1'b1, 1'b0);
		restart(1'b0);
		rdchk(ADDR_STATUS, 16'h0032);
		pulse(1);
		rdchk(ADDR_STATUS, 16'h0002);
		mdl.fire(1'b0, 1'b1);
		restart(1'b0);
		rdchk(ADDR_STATUS, 16'h0032);
		pulse(1);
		mdl.fire(1'b0, 1'b0);
		pulse(2);
		@(posedge core_clk_i) #1 chk({15'h0, pending}, 16'h0000);
		restart(1'b0);
		rdchk(ADDR_STATUS, 16'h0002);
		// Trip while the speed search still runs: back to idle, no calm reload
		mdl.lat = 30;
		mdl.fire(1'b0, 1'b0);
		repeat (40) @(posedge core_clk_i);
		mdl.fire(1'b0, 1'b0);
		rdchk(ADDR_STATUS, 16'h0001);
		repeat (80) @(posedge core_clk_i);
		rdchk(ADDR_STATUS, 16'h0001);
		tally_and_finish();
	end
endmodule : auto_restart_controller_bench
`default_nettype wire
